/* File: async_serial_port_core.sv */
// Asynchronous serial port core: mode, status, buffers, framer, receiver.
// Assumes base_tick_i is a one-cycle enable from an outside baud divider,
// and that serial_in_pin_i is already synchronous to core_clk_i.
//
// Summary of operation
// - Shift serial input, load receive buffer after stop
// - Seven-bit characters read zero in bit seven
// - Buffer load raises reception-complete interrupt
// - Transmit buffer write starts transmission when enabled
// - Frame end raises transmission-complete interrupt
// - Frame with start, parity, stop bits per mode
// - Mode register byte or bit access, reset 01H
// - Unit disabled holds port reset, clears status
// - Unit enable falling initialises port registers except transmit buffer
// - Serial output high whenever transmission disabled
// - Section reinit by clearing enable two base clocks
// - Parity field: none, zero, odd, even
// - Zero parity never sets parity error
// - Length bit selects seven or eight bits
// - Stop bit count transmit only, receive one
// - Error mode steers error to one interrupt
// - Reception disabled: no start, no shift, buffer kept
// - Reception enabled: start bit begins frame reception
// - Error status read clears, enable clears too
// - Overrun sets flag and discards new character
// - Framing error checks only first stop bit
module async_serial_port_core #(
    parameter int TICKS_PER_BIT = serial_port_pkg::BASE_TICKS_PER_BIT
) (
    input  wire logic       core_clk_i,          // Core clock, 10 MHz
    input  wire logic       resetn_i,            // Async reset, active low
    input  wire logic [2:0] reg_addr_i,          // Register offset
    input  wire logic [7:0] reg_wdata_i,         // Write data
    input  wire logic       reg_wr_i,            // Write strobe
    input  wire logic       reg_rd_i,            // Read strobe
    output logic      [7:0] reg_rdata_o,         // Read data, next cycle
    input  wire logic       base_tick_i,         // Base-clock enable pulse
    input  wire logic       serial_in_pin_i,     // Receive line
    output logic            serial_out_pin_o,    // Transmit line
    output logic            rx_complete_irq_o,   // Reception complete pulse
    output logic            rx_error_irq_o,      // Reception error pulse
    output logic            tx_complete_irq_o    // Transmission done pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int TW = $clog2(TICKS_PER_BIT + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICKS_PER_BIT - 1);
    localparam logic [TW-1:0] TICK_HALF = TW'(TICKS_PER_BIT / 2 - 1);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_st_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_st_t;
    serial_port_pkg::mode_t     mode_r;          // Mode control register
    serial_port_pkg::mode_t     mode_nxt;        // Mode after a write
    serial_port_pkg::err_stat_t err_r;           // Error flags
    logic [7:0]  rx_buf_r;                       // Receive buffer
    logic        rx_unread_r;                    // Buffer not yet read
    logic [7:0]  tx_buf_r;                       // Transmit buffer
    logic        tx_full_r;                      // Buffer holds next char
    logic        tx_shifting_r;                  // Frame in progress
    logic [7:0]  reg_rdata_r;                    // Registered read data
    rx_st_t      rx_st_r;                        // Receiver state
    logic [TW-1:0] rx_tick_r;                    // Ticks within a bit
    logic [3:0]  rx_bit_r;                       // Bits received so far
    logic [8:0]  rx_sh_r;                        // Data plus parity
    tx_st_t      tx_st_r;                        // Transmitter state
    logic [TW-1:0] tx_tick_r;                    // Ticks within a bit
    logic [3:0]  tx_left_r;                      // Bits left in frame
    logic [11:0] tx_sh_r;                        // Frame shift register
    logic        port_run;                       // Unit enabled
    logic        tx_run;                         // Transmit section running
    logic        rx_run;                         // Receive section running
    logic        wr_mode;                        // Any mode write
    logic        rd_err;                         // Error status read
    logic        rd_rxb;                         // Receive buffer read
    logic        wr_txb;                         // Transmit buffer write
    logic [3:0]  char_len;                       // 7 or 8
    logic        par_on;                         // Parity bit present
    logic        tx_load;                        // Buffer to shifter
    logic        tx_done;                        // Last stop bit ended
    logic        rx_done;                        // Stop bit sampled
    logic        rx_pe;                          // Parity mismatch
    logic        rx_fe;                          // Stop bit low
    logic        rx_ove;                         // Buffer still unread
    logic [7:0]  rx_data;                        // Masked character
    logic [11:0] tx_frame;                       // Assembled frame
    logic [3:0]  tx_nbits;                       // Bits in frame

    ////////////////////////////////////////////////////////////////////////
    // Decode and mode fields
    // disabled unit holds sections
    assign port_run = mode_r.unit_enable;
    assign tx_run   = port_run & mode_r.transmit_enable;
    assign rx_run   = port_run & mode_r.receive_enable;
    assign wr_mode  = reg_wr_i & ((reg_addr_i == serial_port_pkg::OFF_MODE) |
                      (reg_addr_i == serial_port_pkg::OFF_MODE_BIT));
    assign rd_err   = reg_rd_i & (reg_addr_i == serial_port_pkg::OFF_ERR_STAT);
    assign rd_rxb   = reg_rd_i & (reg_addr_i == serial_port_pkg::OFF_RX_BUF);
    assign wr_txb   = reg_wr_i & (reg_addr_i == serial_port_pkg::OFF_TX_BUF);
    // length bit selects 7 or 8
    assign char_len = mode_r.char_length_sel ? 4'h8 : 4'h7;
    assign par_on   = (mode_r.parity_select != serial_port_pkg::PAR_NONE);
    // Mode value after a byte or single-bit write
    always_comb begin
        mode_nxt = mode_r;
        if (reg_addr_i == serial_port_pkg::OFF_MODE) begin
            mode_nxt = serial_port_pkg::mode_t'(reg_wdata_i);
        end else begin
            mode_nxt[reg_wdata_i[serial_port_pkg::BITWR_IDX_LSB +: 3]] =
                reg_wdata_i[serial_port_pkg::BITWR_VAL_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= serial_port_pkg::mode_t'(serial_port_pkg::MODE_RST);
        end else if (wr_mode) begin
            if (mode_r.unit_enable && !mode_nxt.unit_enable) begin
                mode_r <= serial_port_pkg::mode_t'(serial_port_pkg::MODE_RST);
            end else begin
                mode_r <= mode_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stands one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_r <= serial_port_pkg::RDATA_RST;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                serial_port_pkg::OFF_MODE:     reg_rdata_r <= mode_r;
                serial_port_pkg::OFF_ERR_STAT: reg_rdata_r <= {5'h00, err_r};
                serial_port_pkg::OFF_TX_STAT:  reg_rdata_r <= {6'h00,
                                                   tx_full_r, tx_shifting_r};
                serial_port_pkg::OFF_RX_BUF:   reg_rdata_r <= rx_buf_r;
                default:                       reg_rdata_r <= 8'h00;
            endcase
        end else begin
            // Data valid only in the cycle after the strobe
            reg_rdata_r <= serial_port_pkg::RDATA_RST;
        end
    end
    assign reg_rdata_o = reg_rdata_r;
    ////////////////////////////////////////////////////////////////////////
    // Transmit frame assembly
    always_comb begin
        logic par_bit;
        par_bit  = 1'b0;
        tx_frame = 12'hFFF;                      // Idle ones fill stop bits
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < char_len) begin
                tx_frame[i + 1] = tx_buf_r[i];
            end
        end
        case (mode_r.parity_select)
            serial_port_pkg::PAR_ODD:  par_bit = ~^(tx_buf_r & {
                                           mode_r.char_length_sel, 7'h7F});
            serial_port_pkg::PAR_EVEN: par_bit = ^(tx_buf_r & {
                                           mode_r.char_length_sel, 7'h7F});
            default:                   par_bit = 1'b0;
        endcase
        if (par_on) begin
            tx_frame[char_len + 4'h1] = par_bit;
        end
        tx_nbits = 4'h2 + char_len + {3'h0, par_on} +
                   {3'h0, mode_r.stop_length_sel};
    end
    // load when shifter free and enabled
    assign tx_load = tx_run && tx_full_r && (tx_st_r == TX_IDLE);
    assign tx_done = (tx_st_r == TX_SHIFT) && base_tick_i &&
                     (tx_tick_r == TICK_LAST) && (tx_left_r == 4'h1);
    ////////////////////////////////////////////////////////////////////////
    // Transmit buffer and its full flag
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_buf_r  <= serial_port_pkg::TX_BUF_RST;
            tx_full_r <= 1'b0;
        end else if (!tx_run) begin
            // Disabled section drops any pending character
            tx_full_r <= 1'b0;
        end else if (wr_txb) begin
            // Write wins; overwriting a full buffer is not guaranteed
            tx_buf_r  <= reg_wdata_i;
            tx_full_r <= 1'b1;
        end else if (tx_load) begin
            tx_full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit shifter
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_st_r       <= TX_IDLE;
            tx_tick_r     <= '0;
            tx_left_r     <= 4'h0;
            tx_sh_r       <= 12'hFFF;
            tx_shifting_r <= 1'b0;
        end else if (!tx_run) begin
            tx_st_r       <= TX_IDLE;
            tx_sh_r       <= 12'hFFF;
            tx_shifting_r <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_r       <= tx_frame;
                        tx_left_r     <= tx_nbits;
                        tx_tick_r     <= '0;
                        tx_shifting_r <= 1'b1;
                        tx_st_r       <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (base_tick_i) begin
                        if (tx_tick_r == TICK_LAST) begin
                            tx_tick_r <= '0;
                            tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                            tx_left_r <= tx_left_r - 4'h1;
                            if (tx_left_r == 4'h1) begin
                                tx_st_r       <= TX_IDLE;
                                tx_shifting_r <= 1'b0;
                            end
                        end else begin
                            tx_tick_r <= tx_tick_r + TW'(1);
                        end
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end
    assign serial_out_pin_o = tx_run ? tx_sh_r[0] : 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Receive result evaluation at the stop-bit sample
    always_comb begin
        logic par_rx;
        par_rx  = 1'b0;
        // bit seven zero for short chars
        rx_data = mode_r.char_length_sel ? rx_sh_r[7:0] :
                                           {1'b0, rx_sh_r[6:0]};
        par_rx  = mode_r.char_length_sel ? rx_sh_r[8] : rx_sh_r[7];
        case (mode_r.parity_select)
            serial_port_pkg::PAR_ODD:  rx_pe = ~(^{rx_data, par_rx});
            serial_port_pkg::PAR_EVEN: rx_pe = ^{rx_data, par_rx};
            default:                   rx_pe = 1'b0;
        endcase
    end
    assign rx_done = (rx_st_r == RX_STOP) && base_tick_i &&
                     (rx_tick_r == TICK_LAST);
    assign rx_fe   = !serial_in_pin_i;
    // A read in the same cycle counts as done first
    assign rx_ove  = rx_unread_r && !rd_rxb;
    ////////////////////////////////////////////////////////////////////////
    // Receiver sequencer
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_r   <= RX_IDLE;
            rx_tick_r <= '0;
            rx_bit_r  <= 4'h0;
            rx_sh_r   <= 9'h000;
        end else if (!rx_run) begin
            rx_st_r <= RX_IDLE;
        end else if (base_tick_i) begin
            case (rx_st_r)
                RX_IDLE: begin
                    if (!serial_in_pin_i) begin
                        rx_st_r   <= RX_START;
                        rx_tick_r <= '0;
                    end
                end
                RX_START: begin
                    if (rx_tick_r == TICK_HALF) begin
                        rx_tick_r <= '0;
                        rx_bit_r  <= 4'h0;
                        rx_st_r   <= serial_in_pin_i ? RX_IDLE : RX_BITS;
                    end else begin
                        rx_tick_r <= rx_tick_r + TW'(1);
                    end
                end
                RX_BITS: begin
                    if (rx_tick_r == TICK_LAST) begin
                        rx_tick_r <= '0;
                        rx_sh_r[rx_bit_r] <= serial_in_pin_i;
                        rx_bit_r  <= rx_bit_r + 4'h1;
                        if (rx_bit_r + 4'h1 == char_len + {3'h0, par_on}) begin
                            rx_st_r <= RX_STOP;
                        end
                    end else begin
                        rx_tick_r <= rx_tick_r + TW'(1);
                    end
                end
                RX_STOP: begin
                    if (rx_tick_r == TICK_LAST) begin
                        rx_st_r <= RX_IDLE;
                    end else begin
                        rx_tick_r <= rx_tick_r + TW'(1);
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and its unread flag
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_buf_r    <= serial_port_pkg::RX_BUF_RST;
            rx_unread_r <= 1'b0;
        end else if (!port_run) begin
            rx_buf_r    <= serial_port_pkg::RX_BUF_RST;
            rx_unread_r <= 1'b0;
        end else if (rx_done && rx_run && !rx_ove) begin
            rx_buf_r    <= rx_data;
            rx_unread_r <= 1'b1;
        end else if (rd_rxb) begin
            rx_unread_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error status flags
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_r <= serial_port_pkg::err_stat_t'(serial_port_pkg::ERR_RST);
        end else if (!rx_run) begin
            err_r <= serial_port_pkg::err_stat_t'(serial_port_pkg::ERR_RST);
        end else if (rx_done) begin
            // Set wins over a read in the same cycle
            err_r.parity_error_flag  <= rx_pe |
                                        (err_r.parity_error_flag & !rd_err);
            err_r.framing_error_flag <= rx_fe |
                                        (err_r.framing_error_flag & !rd_err);
            err_r.overrun_flag       <= rx_ove |
                                        (err_r.overrun_flag & !rd_err);
        end else if (rd_err) begin
            err_r <= serial_port_pkg::err_stat_t'(serial_port_pkg::ERR_RST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request pulses, registered
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_complete_irq_o <= 1'b0;
            rx_error_irq_o    <= 1'b0;
            tx_complete_irq_o <= 1'b0;
        end else begin
            tx_complete_irq_o <= tx_done && tx_run;
            if (rx_done && rx_run) begin
                if (rx_pe || rx_fe || rx_ove) begin
                    rx_complete_irq_o <= mode_r.error_irq_mode;
                    rx_error_irq_o    <= !mode_r.error_irq_mode;
                end else begin
                    rx_complete_irq_o <= 1'b1;
                    rx_error_irq_o    <= 1'b0;
                end
            end else begin
                rx_complete_irq_o <= 1'b0;
                rx_error_irq_o    <= 1'b0;
            end
        end
    end
endmodule

/* File: async_serial_port_core_monitor.sv */
// Port checker for the serial port core.
// Assumes it is bound to the core and sees only the core's ports.
module async_serial_port_core_monitor #(parameter int TICKS_PER_BIT = 16) (
    input wire logic       core_clk_i,        // Core clock
    input wire logic       resetn_i,          // Async reset, active low
    input wire logic       reg_wr_i,          // Write strobe
    input wire logic       reg_rd_i,          // Read strobe
    input wire logic [2:0] reg_addr_i,        // Register offset
    input wire logic [7:0] reg_wdata_i,       // Write data
    input wire logic [7:0] reg_rdata_o,       // Read data
    input wire logic       base_tick_i,       // Base-clock pulse
    input wire logic       serial_in_pin_i,   // Receive line
    input wire logic       serial_out_pin_o,  // Transmit line
    input wire logic       rx_complete_irq_o, // Reception complete
    input wire logic       rx_error_irq_o,    // Reception error
    input wire logic       tx_complete_irq_o  // Transmission done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not idle");
    a_irq_exclusive: assert property
        (!(rx_complete_irq_o && rx_error_irq_o))
        else $error("both receive irqs");
    a_rx_pulse: assert property (rx_complete_irq_o |=> !rx_complete_irq_o)
        else $error("rx irq too long");
    a_err_pulse: assert property (rx_error_irq_o |=> !rx_error_irq_o)
        else $error("error irq too long");
    a_tx_pulse: assert property (tx_complete_irq_o |=> !tx_complete_irq_o)
        else $error("tx irq too long");
    a_rx_on_tick: assert property (rx_complete_irq_o || rx_error_irq_o
        |-> $past(base_tick_i)) else $error("rx irq off tick");
    a_tx_on_tick: assert property
        (tx_complete_irq_o |-> $past(base_tick_i))
        else $error("tx irq off tick");
    a_start_held: assert property
        ($fell(serial_out_pin_o) |=> !serial_out_pin_o)
        else $error("start bit too short");
    // Reset must quiet the transmit line, tx irq and read data, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0) !resetn_i
        |-> serial_out_pin_o && !tx_complete_irq_o && reg_rdata_o == 8'h00)
        else $error("outputs busy in reset");
endmodule
bind async_serial_port_core async_serial_port_core_monitor
    #(.TICKS_PER_BIT(TICKS_PER_BIT)) mon (.*);

/* File: serial_port_pkg.sv */
// Package for the asynchronous serial port core: offsets, layouts, resets.
// Assumes a single core clock and a base-clock enable pulse from outside.
package serial_port_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port
    localparam logic [2:0] OFF_MODE     = 3'h0; // Mode control, read/write
    localparam logic [2:0] OFF_ERR_STAT = 3'h1; // Error status, read clears
    localparam logic [2:0] OFF_TX_STAT  = 3'h2; // Transmit status, read only
    localparam logic [2:0] OFF_RX_BUF   = 3'h3; // Receive buffer, read only
    localparam logic [2:0] OFF_TX_BUF   = 3'h4; // Transmit buffer, write only
    localparam logic [2:0] OFF_MODE_BIT = 3'h5; // Single-bit write of mode

    // Single-bit write layout: value bit and bit index
    localparam int BITWR_VAL_POS = 7;       // New bit value
    localparam int BITWR_IDX_LSB = 0;       // Index, three bits wide

    ////////////////////////////////////////////////////////////////////////
    // Mode register layout, most significant field first
    typedef struct packed {
        logic       unit_enable;            // Bit 7: clock and reset gate
        logic       transmit_enable;        // Bit 6
        logic       receive_enable;         // Bit 5
        logic [1:0] parity_select;          // Bits 4:3, hi then lo
        logic       char_length_sel;        // Bit 2: 0 seven, 1 eight
        logic       stop_length_sel;        // Bit 1: 0 one, 1 two
        logic       error_irq_mode;         // Bit 0
    } mode_t;

    // Error status layout
    typedef struct packed {
        logic       parity_error_flag;      // Bit 2
        logic       framing_error_flag;     // Bit 1
        logic       overrun_flag;           // Bit 0
    } err_stat_t;

    // Parity field codes
    localparam logic [1:0] PAR_NONE = 2'h0; // No parity bit
    localparam logic [1:0] PAR_ZERO = 2'h1; // Zero bit, never judged
    localparam logic [1:0] PAR_ODD  = 2'h2; // Odd parity
    localparam logic [1:0] PAR_EVEN = 2'h3; // Even parity

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] MODE_RST     = 8'h01; // Mode control
    localparam logic [2:0] ERR_RST      = 3'h0;  // Error status
    localparam logic [7:0] RX_BUF_RST   = 8'hFF; // Receive buffer
    localparam logic [7:0] TX_BUF_RST   = 8'h00; // Transmit buffer
    localparam logic [7:0] RDATA_RST    = 8'h00; // Read data

    // Transmit status bit positions
    localparam int TXST_FULL_POS  = 1;      // Buffer holds next char
    localparam int TXST_SHIFT_POS = 0;      // Frame in progress

    // Base-clock ticks per serial bit (default)
    localparam int BASE_TICKS_PER_BIT = 16;

endpackage

/* File: serial_remote_node.sv */
// Remote serial node: sends frames to the core and captures its output.
// Assumes base_tick_i paces both sides, TPB ticks to a bit.
module serial_remote_node #(parameter int TPB = 4) (
    input  wire logic core_clk_i,  // Core clock
    input  wire logic base_tick_i, // Bit pacing tick
    input  wire logic line_i,      // Core transmit line
    output logic      line_o       // Core receive line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    task automatic ticks(input int n);
        repeat (n) do @(posedge core_clk_i); while (!base_tick_i);
    endtask
    // Bits leave LSB first; line released high afterwards
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            ticks(TPB);
        end
        line_o <= 1'b1;
    endtask
    // Sample each bit near its centre after the start edge
    task automatic grab(output logic [11:0] f, input int n);
        f = 12'h000;
        @(negedge line_i);
        ticks(TPB / 2);
        for (int i = 0; i < n; i++) begin
            ticks(TPB);
            f[i] = line_i;
        end
    endtask
endmodule

/* File: tb_async_serial_port_core.sv */
// Self-checking bench for the serial port core.
// Assumes the remote node model and the bound port checker.
module tb_async_serial_port_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TPB = 4; // Short bit time keeps the run brief
    logic        clk = 0, rstn = 1, wr_s = 0, rd_s = 0, tick = 0;
    logic        rxd, txd, rxc, rxe, txc;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [11:0] got;
    int          mismatches = 0, samples_checked = 0, cyc = 0;
    always #50 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    async_serial_port_core #(.TICKS_PER_BIT(TPB)) uut (.core_clk_i(clk),
        .resetn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .base_tick_i(tick), .serial_in_pin_i(rxd), .serial_out_pin_o(txd),
        .rx_complete_irq_o(rxc), .rx_error_irq_o(rxe), .tx_complete_irq_o(txc));
    serial_remote_node #(.TPB(TPB)) peer (.core_clk_i(clk),
        .base_tick_i(tick), .line_i(txd), .line_o(rxd));
    task automatic chk(input logic [11:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(posedge clk) chk(rdata, exp);
    endtask
    // Bounded wait: 0 rx done, 1 rx error, 2 tx done
    task automatic await(input int k);
        int n;
        n = 0;
        while (n < 300 && (k == 0 ? rxc : k == 1 ? rxe : txc) !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(n < 300, 12'h001);
    endtask
    task automatic conclude;
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 20000) begin
        mismatches++;
        conclude();
    end
    task automatic t_frames;
        rd(serial_port_pkg::OFF_MODE, 8'h01);
        rd(serial_port_pkg::OFF_RX_BUF, 8'hFF);
        rd(3'h7, 8'h00);
        wr(serial_port_pkg::OFF_MODE, 8'h80);
        wr(serial_port_pkg::OFF_MODE, 8'hFE);
        fork peer.grab(got, 11);
            begin wr(serial_port_pkg::OFF_TX_BUF, 8'hA7); await(2); end
        join
        chk(got, 12'h7A7);
        fork peer.send(12'h478, 11); await(0); join
        rd(serial_port_pkg::OFF_RX_BUF, 8'h3C);
        fork peer.send(12'h678, 11); await(1); join
        rd(serial_port_pkg::OFF_ERR_STAT, 8'h04);
        rd(serial_port_pkg::OFF_ERR_STAT, 8'h00);
        fork peer.send(12'h502, 11); await(1); join
        rd(serial_port_pkg::OFF_ERR_STAT, 8'h01);
        rd(serial_port_pkg::OFF_RX_BUF, 8'h3C);
        $display("frame test done");
    endtask
    task automatic t_short;
        wr(serial_port_pkg::OFF_MODE, 8'h80);
        repeat (4) @(posedge clk);
        wr(serial_port_pkg::OFF_MODE, 8'hEA);
        fork peer.send(12'h3AA, 10); await(0); join
        rd(serial_port_pkg::OFF_RX_BUF, 8'h55);
        rd(serial_port_pkg::OFF_ERR_STAT, 8'h00);
        fork peer.grab(got, 9);
            begin wr(serial_port_pkg::OFF_TX_BUF, 8'hD5); await(2); end
        join
        chk(got, 12'h155);
        wr(serial_port_pkg::OFF_MODE, 8'h80);
        peer.send(12'h6AA, 11);
        rd(serial_port_pkg::OFF_RX_BUF, 8'h55);
        wr(serial_port_pkg::OFF_MODE, 8'h00);
        rd(serial_port_pkg::OFF_MODE, 8'h01);
        rd(serial_port_pkg::OFF_RX_BUF, 8'hFF);
        wr(serial_port_pkg::OFF_MODE_BIT, 8'h00);
        rd(serial_port_pkg::OFF_MODE, 8'h00);
        $display("short test done");
    endtask
    initial begin
        // Reset edge at time zero, seen by the async reset
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_frames();
        t_short();
        conclude();
    end
endmodule
